//--- common/swpc_pkg.sv
package swpc_pkg;
  // Power modes seen by the controller side
  typedef enum logic [1:0] {
    SWPC_RUN = 2'h0,
    SWPC_STANDBY = 2'h1,
    SWPC_DORMANT = 2'h2,
    SWPC_SHUTDOWN = 2'h3
  } swpc_mode_type;

  // Device sequencer states, one-hot
  typedef enum logic [4:0] {
    SWPC_S_RUN = 5'h01,
    SWPC_S_DRAIN = 5'h02,
    SWPC_S_STANDBY = 5'h04,
    SWPC_S_SLAVE = 5'h08,
    SWPC_S_WAKE = 5'h10
  } swpc_state_type;

  localparam logic [1:0] SWPC_MODE_RESET = 2'h0;
  localparam logic [1:0] SWPC_MODE_RUN = 2'h0;
endpackage : swpc_pkg

//--- common/swpc_if.sv
`timescale 1ns/1ps
// Link between the processor power logic and the power management controller
interface swpc_if;
  logic standbyIndicator;
  logic modeReqValid;
  logic [1:0] modeReq;
  logic activeLowReset;
  logic powerOn;
  modport device (output standbyIndicator, output modeReqValid, output modeReq,
    input activeLowReset, input powerOn);
  modport controller (input standbyIndicator, input modeReqValid, input modeReq,
    output activeLowReset, output powerOn);
endinterface : swpc_if

//--- design/swpc_device.sv
`timescale 1ns/1ps
module swpc_device (
  input wire logic core_clk,
  input wire logic rst,
  swpc_if.device link,
  input wire logic waitForInterruptInstr,
  input wire logic memAccessPending,
  input wire logic [7:0] irqLines,
  input wire logic externalDebugRequest,
  input wire logic debugBusHalt,
  input wire logic slaveTxnValid,
  input wire logic slaveTxnDone,
  input wire logic modeWrite,
  input wire logic [1:0] modeWriteData,
  output logic coreClkEnable,
  output logic wfiDone,
  output logic inStandby
);
  import swpc_pkg::*;

  // ----------------------------------------
  // Input synchronisers (pins from outside)
  // ----------------------------------------
  logic [$bits(irqLines)-1:0] irqSyncd;
  logic [1:0] dbgRaw;
  logic [1:0] dbgMeta_q;
  logic [1:0] dbgSync_q;
  genvar gi;

  // One two-flop chain per interrupt line; the lines are only ORed after
  // the second flop, so no gate can glitch into a first stage
  generate
    for (gi = 0; gi < $bits(irqLines); gi++) begin : g_irqSync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'h0;
          sync_q <= 1'h0;
        end else begin
          meta_q <= irqLines[gi];
          sync_q <= meta_q;
        end
      end
      assign irqSyncd[gi] = sync_q; // Only the second flop is read
    end
  endgenerate

  // Pin request and bus halt travel side by side
  assign dbgRaw = {externalDebugRequest, debugBusHalt};

  // Two flops for the debug levels; both idle low, so no false wake
  // follows the release of reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dbgMeta_q <= 2'h0;
      dbgSync_q <= 2'h0;
    end else begin
      dbgMeta_q <= dbgRaw;
      dbgSync_q <= dbgMeta_q;
    end
  end

  // ----------------------------------------
  // Wake decode
  // ----------------------------------------
  logic irqSeen;
  logic debugWake;
  logic resetReq;
  logic sourceWake;
  logic wake;

  // Interrupt and debug wake need a powered core; the reset line is
  // launched by a flop on this same clock and so needs no chain
  assign irqSeen = |irqSyncd; // Mask state is never consulted
  assign debugWake = |dbgSync_q; // Debug enable is not checked
  assign resetReq = ~link.activeLowReset; // Reset also leaves Standby
  assign sourceWake = (irqSeen | debugWake) & link.powerOn;
  assign wake = sourceWake | resetReq;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  swpc_state_type state_q, state_d;

  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      SWPC_S_RUN: begin
        if (waitForInterruptInstr) begin
          state_d = SWPC_S_DRAIN; // Only the wait instruction enters
        end
      end
      SWPC_S_DRAIN: begin
        if (!memAccessPending) begin
          state_d = SWPC_S_STANDBY; // Barrier complete
        end
      end
      SWPC_S_STANDBY: begin
        if (wake) begin
          state_d = SWPC_S_WAKE;
        end else if (slaveTxnValid) begin
          state_d = SWPC_S_SLAVE;
        end
      end
      SWPC_S_SLAVE: begin
        if (slaveTxnDone) begin
          state_d = SWPC_S_STANDBY; // Back to Standby, not Run
        end
      end
      SWPC_S_WAKE: begin
        state_d = SWPC_S_RUN;
      end
      default: begin
        state_d = SWPC_S_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // Registers and outputs
  // ----------------------------------------
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic reqValid_q;
  logic clkEn_q;
  logic clkEn_d;
  logic standby_q;
  logic standby_d;
  logic done_q;
  logic done_d;
  logic inSb_q;
  logic inSb_d;

  // Next values; the clock gate and the indicator share one decode so
  // the indicator can never rise while the core clock still runs
  assign mode_d = modeWrite ? modeWriteData : mode_q;
  assign clkEn_d = (state_d != SWPC_S_STANDBY); // Run and slave service clocked
  assign standby_d = (state_d == SWPC_S_STANDBY); // Also for shutdown wait
  assign done_d = (state_q == SWPC_S_WAKE); // Resume only after restart
  assign inSb_d = (state_d == SWPC_S_STANDBY) || (state_d == SWPC_S_SLAVE);

  // Sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= SWPC_S_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Mode request held for the controller, valid strobe one cycle after each modeWrite cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= SWPC_MODE_RESET;
      reqValid_q <= 1'h0;
    end else begin
      mode_q <= mode_d;
      reqValid_q <= modeWrite; // Ordered mapped access forwarded
    end
  end

  // Clock gate and standby indicator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkEn_q <= 1'h1;
      standby_q <= 1'h0;
    end else begin
      clkEn_q <= clkEn_d;
      standby_q <= standby_d;
    end
  end

  // Resume pulse and standby level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'h0;
      inSb_q <= 1'h0;
    end else begin
      done_q <= done_d;
      inSb_q <= inSb_d;
    end
  end

  // Ports come straight from the flops above
  assign coreClkEnable = clkEn_q;
  assign wfiDone = done_q;
  assign inStandby = inSb_q;
  assign link.standbyIndicator = standby_q;
  assign link.modeReqValid = reqValid_q;
  assign link.modeReq = mode_q;
endmodule : swpc_device

//--- design/swpc_controller.sv
`timescale 1ns/1ps
// Power management controller end
module swpc_controller #(
  parameter int RESET_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  swpc_if.controller link,
  output logic [1:0] appliedMode,
  output logic powerDownActive
);
  import swpc_pkg::*;

  logic [1:0] req_q;
  logic [7:0] rstCnt_q;
  logic standbySeen;
  assign standbySeen = link.standbyIndicator;

  // Decode requests, apply a deep mode when indicator high, restore and pulse reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_q <= SWPC_MODE_RESET;
      rstCnt_q <= 8'h00;
      link.powerOn <= 1'b1;
      link.activeLowReset <= 1'b1;
      appliedMode <= SWPC_MODE_RESET;
      powerDownActive <= 1'b0;
    end else begin
      if (link.modeReqValid) begin
        req_q <= link.modeReq;
      end
      if (powerDownActive && !link.modeReqValid && req_q == SWPC_MODE_RUN) begin
        // Restore power and assert reset in the same cycle, release it later
        link.powerOn <= 1'b1;
        powerDownActive <= 1'b0;
        appliedMode <= SWPC_MODE_RUN;
        link.activeLowReset <= 1'b0;
        rstCnt_q <= 8'(RESET_CYCLES);
      end else if (standbySeen && !powerDownActive &&
          (req_q == SWPC_DORMANT || req_q == SWPC_SHUTDOWN)) begin
        link.powerOn <= 1'b0; // Indicator says ready
        powerDownActive <= 1'b1;
        appliedMode <= req_q;
      end
      if (rstCnt_q != 8'h00) begin
        rstCnt_q <= rstCnt_q - 8'h01;
        if (rstCnt_q == 8'h01) begin
          link.activeLowReset <= 1'b1;
        end
      end
    end
  end
endmodule : swpc_controller

//--- tb/swpc_assertions.sv
`timescale 1ns/1ps
// ---
// Link checker
// ---
module swpc_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standbyIndicator,
  input wire logic modeReqValid,
  input wire logic [1:0] modeReq,
  input wire logic activeLowReset,
  input wire logic powerOn
);
  // Remembers whether the last request asked for a deep mode
  logic deep_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) deep_q <= 1'h0;
    else if (modeReqValid) deep_q <= modeReq[1];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Request, power and reset sequencing
  property p_pulse; modeReqValid |=> !modeReqValid; endproperty
  a_pulse: assert property (p_pulse) else $error("long req");
  property p_offIdle; $fell(powerOn) |-> $past(standbyIndicator); endproperty
  a_offIdle: assert property (p_offIdle) else $error("off early");
  property p_offDeep; $fell(powerOn) |-> deep_q; endproperty
  a_offDeep: assert property (p_offDeep) else $error("off no req");
  property p_onRst; $rose(powerOn) |-> ##[0:8] !activeLowReset; endproperty
  a_onRst: assert property (p_onRst) else $error("no rst");
  property p_rstLen; $fell(activeLowReset) |-> ##[1:8] activeLowReset; endproperty
  a_rstLen: assert property (p_rstLen) else $error("rst stuck");
  property p_relOn; $rose(activeLowReset) |-> powerOn; endproperty
  a_relOn: assert property (p_relOn) else $error("rel unpowered");
  property p_rstQuiet; !activeLowReset && $past(!activeLowReset) |-> !modeReqValid; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("req in rst");
  property p_rstRun; $fell(activeLowReset) |-> ##[0:2] !standbyIndicator; endproperty
  a_rstRun: assert property (p_rstRun) else $error("rst kept sb");
  // Main scenarios
  cover property ($rose(standbyIndicator));
  cover property ($fell(powerOn));
  cover property ($rose(activeLowReset));
endmodule : swpc_assertions

//--- tb/tb_standby_wfi_power_control.sv
`timescale 1ns/1ps
module tb_standby_wfi_power_control;
  import swpc_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1, wfi = 1'h0, pend = 1'h0, edbg = 1'h0;
  logic halt = 1'h0, sv = 1'h0, sd = 1'h0, mw = 1'h0, cke, done, inSb, pdn;
  logic [7:0] irq = 8'h00;
  logic [1:0] mwd = 2'h0, applied;
  logic [31:0] lf = 32'h00012F63;
  int err_count = 0, checks = 0;
  swpc_if link ();
  always #4 core_clk = ~core_clk;
  swpc_device u_swpc_device (.core_clk(core_clk), .rst(rst), .link(link),
    .waitForInterruptInstr(wfi), .memAccessPending(pend), .irqLines(irq),
    .externalDebugRequest(edbg), .debugBusHalt(halt), .slaveTxnValid(sv),
    .slaveTxnDone(sd), .modeWrite(mw), .modeWriteData(mwd), .coreClkEnable(cke),
    .wfiDone(done), .inStandby(inSb));
  swpc_controller #(.RESET_CYCLES(2)) u_swpc_controller (.core_clk(core_clk),
    .rst(rst), .link(link), .appliedMode(applied), .powerDownActive(pdn));
  swpc_assertions u_swpc_assertions (.core_clk(core_clk), .rst(rst),
    .standbyIndicator(link.standbyIndicator), .modeReqValid(link.modeReqValid),
    .modeReq(link.modeReq), .activeLowReset(link.activeLowReset), .powerOn(link.powerOn));
  function logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task chk(logic [7:0] g, logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task waitFor(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) cyc(1);
  endtask : waitFor
  task results;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    cyc(3000);
    err_count++;
    results();
  end
  // Enter standby, service a slave access, then wake by interrupt, debug request and bus halt, and last leave by rst
  initial begin
    cyc(3);
    rst = 1'h0;
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      pend = 1'h1;
      wfi = 1'h1;
      cyc(1);
      wfi = 1'h0;
      cyc(1 + lf[9:8]);
      chk(link.standbyIndicator, 8'h00);
      pend = 1'h0;
      waitFor(link.standbyIndicator, 1'h1);
      chk(link.standbyIndicator, 8'h01);
      chk(cke, 8'h00);
      sv = 1'h1;
      cyc(1);
      sv = 1'h0;
      cyc(1);
      chk({inSb, cke, link.standbyIndicator}, 8'h06);
      sd = 1'h1;
      cyc(1);
      sd = 1'h0;
      waitFor(link.standbyIndicator, 1'h1);
      chk(inSb, 8'h01);
      irq = (k == 0) ? (lf[7:0] | 8'h01) : 8'h00;
      edbg = (k == 1);
      halt = (k == 2);
      rst = (k == 3);
      cyc(1);
      rst = 1'h0;
      if (k < 3) waitFor(done, 1'h1);
      if (k < 3) chk(done, 8'h01);
      {irq, edbg, halt} = 10'h000;
      cyc(1);
      chk({cke, link.standbyIndicator}, 8'h02);
    end
    // Deep modes, both of them: power is removed, then restored with a reset pulse
    for (int m = 0; m < 2; m++) begin
      mwd = {1'h1, lf[0] ^ m[0]};
      mw = 1'h1;
      cyc(1);
      mw = 1'h0;
      wfi = 1'h1; // Interrupts quiet, no pending access
      cyc(1);
      wfi = 1'h0;
      waitFor(link.standbyIndicator, 1'h1);
      chk(link.standbyIndicator, 8'h01);
      waitFor(pdn, 1'h1);
      chk({pdn, applied}, {5'h00, 1'h1, mwd});
      chk(link.powerOn, 8'h00);
      mwd = 2'h0;
      mw = 1'h1;
      cyc(1);
      mw = 1'h0;
      waitFor(link.activeLowReset, 1'h0);
      waitFor(link.activeLowReset, 1'h1);
      cyc(2);
      chk({link.powerOn, link.standbyIndicator}, 8'h02);
    end
    results();
  end
endmodule : tb_standby_wfi_power_control
